/* File: hdl/irq_ctrl_pkg.sv */
/*
 * constants shared by the interrupt enable/priority controller:
 * register offsets, field positions, reset values.
 * assumes a 32-bit axi4-lite register bus, one word per register.
 */
package irq_ctrl_pkg;
    localparam int          NUM_SRC        = 6;
    // register byte offsets
    localparam logic [7:0]  OFF_PRIORITY   = 8'hb8;
    localparam logic [7:0]  OFF_ENABLE     = 8'ha8;
    localparam logic [7:0]  OFF_STATUS     = 8'hc0;
    localparam logic [7:0]  OFF_MASK       = 8'hc4;
    localparam logic [7:0]  OFF_PENDING    = 8'hc8;
    localparam logic [7:0]  OFF_SERVICE    = 8'hcc;
    // field positions
    localparam int          BIT_EXT0       = 0;
    localparam int          BIT_TIMER0     = 1;
    localparam int          BIT_EXT1       = 2;
    localparam int          BIT_TIMER1     = 3;
    localparam int          BIT_SERIAL     = 4;
    localparam int          BIT_TIMER2     = 5;
    localparam int          BIT_RSVD       = 6;
    localparam int          BIT_GATE       = 7;
    localparam int          BIT_PRIO_OFF   = 7;
    // status / mask bits
    localparam int          ST_TAKEN_HI    = 0;
    localparam int          ST_TAKEN_LO    = 1;
    localparam int          ST_NEST        = 2;
    localparam int          ST_WIDTH       = 3;
    // reset values
    localparam logic [7:0]  RST_ENABLE     = 8'h00;
    localparam logic [7:0]  RST_PRIORITY   = 8'h00;
    localparam logic [2:0]  RST_MASK       = 3'h0;
    // axi responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

/* File: hdl/irq_arbiter.sv */
/*
 * combinational selection of one interrupt source from the enabled
 * requests, in two priority levels with fixed order by index inside a level.
 * assumes requests already gated by the enable bits.
 */
`timescale 1ns/100ps
module irq_arbiter #(
    parameter int N = 6
) (
    // gated requests and levels
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] high,
    input  wire logic         prio_off,
    // service state
    input  wire logic         in_hi,
    input  wire logic         in_lo,
    // selection
    output logic              grant_valid,
    output logic [N-1:0]      grant_onehot,
    output logic              grant_hi
);
    logic [N-1:0] hi_req;
    logic [N-1:0] lo_req;
    logic [N-1:0] pick;

    function automatic logic [N-1:0] first_set(input logic [N-1:0] v);
        logic [N-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    always_comb begin
        hi_req = prio_off ? '0 : (req & high);
        lo_req = prio_off ? req : (req & ~high);
        pick = '0;
        grant_hi = 1'b0;
        if (|hi_req && !in_hi) begin
            pick = first_set(hi_req);
            grant_hi = 1'b1;
        end else if (|lo_req && !in_hi && !in_lo) begin
            pick = first_set(lo_req);
        end
        grant_onehot = pick;
        grant_valid = |pick;
    end
endmodule

/* File: hdl/irq_enable_priority_ctrl.sv */
/*
 * interrupt enable and priority controller with an axi4-lite register port.
 * assumes the core pulses ACK_IN when it takes the granted request and
 * RETI_IN when a service routine returns; one clock, synchronous reset.
 */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module irq_enable_priority_ctrl #(
    parameter int N = irq_ctrl_pkg::NUM_SRC
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // interrupt sources and core handshake
    input  wire logic [N-1:0] IRQ_SRC,
    input  wire logic        ACK_IN,
    input  wire logic        RETI_IN,
    output logic             IRQ_REQ,
    output logic [N-1:0]     IRQ_SEL,
    output logic             IRQ_HIGH,
    output logic             IRQ,
    // axi4-lite write
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    logic [7:0]   irq_enable_reg_r, irq_enable_reg_nxt;
    logic [7:0]   irq_priority_reg_r, irq_priority_reg_nxt;
    logic [2:0]   status_r, status_nxt;
    logic [2:0]   mask_r, mask_nxt;
    logic         in_hi_r, in_hi_nxt;
    logic         in_lo_r, in_lo_nxt;
    logic         req_r, req_nxt;
    logic [N-1:0] sel_r, sel_nxt;
    logic         high_r, high_nxt;
    logic         irq_r, irq_nxt;
    logic         aw_hold_r, aw_hold_nxt;
    logic         w_hold_r, w_hold_nxt;
    logic [7:0]   aw_addr_r, aw_addr_nxt;
    logic [31:0]  w_data_r, w_data_nxt;
    logic         w_strb0_r, w_strb0_nxt;
    logic         bvalid_r, bvalid_nxt;
    logic [1:0]   bresp_r, bresp_nxt;
    logic         rvalid_r, rvalid_nxt;
    logic [1:0]   rresp_r, rresp_nxt;
    logic [31:0]  rdata_r, rdata_nxt;
    logic         awready_r, awready_nxt;
    logic         wready_r, wready_nxt;
    logic         arready_r, arready_nxt;

    logic         global_irq_gate;
    logic         priority_circuit_off;
    logic [N-1:0] gated;
    logic         grant_valid;
    logic [N-1:0] grant_onehot;
    logic         grant_hi;
    logic         do_write;
    logic         do_read;

    function automatic logic known(input logic [7:0] a);
        return a == irq_ctrl_pkg::OFF_PRIORITY || a == irq_ctrl_pkg::OFF_ENABLE ||
               a == irq_ctrl_pkg::OFF_STATUS || a == irq_ctrl_pkg::OFF_MASK ||
               a == irq_ctrl_pkg::OFF_PENDING || a == irq_ctrl_pkg::OFF_SERVICE;
    endfunction

    assign global_irq_gate      = irq_enable_reg_r[irq_ctrl_pkg::BIT_GATE];
    assign priority_circuit_off = irq_priority_reg_r[irq_ctrl_pkg::BIT_PRIO_OFF];
    assign gated = global_irq_gate ? (IRQ_SRC & irq_enable_reg_r[N-1:0]) : '0;

    irq_arbiter #(.N(N)) u_arb (
        .req          (gated),
        .high         (irq_priority_reg_r[N-1:0]),
        .prio_off     (priority_circuit_off),
        .in_hi        (in_hi_r),
        .in_lo        (in_lo_r),
        .grant_valid  (grant_valid),
        .grant_onehot (grant_onehot),
        .grant_hi     (grant_hi)
    );

    // request offer and service nesting
    always_comb begin
        req_nxt   = grant_valid;
        sel_nxt   = grant_onehot;
        high_nxt  = grant_hi;
        in_hi_nxt = in_hi_r;
        in_lo_nxt = in_lo_r;
        status_nxt = status_r;
        if (ACK_IN && req_r) begin
            if (high_r) begin
                in_hi_nxt = 1'b1;
                status_nxt[irq_ctrl_pkg::ST_TAKEN_HI] = 1'b1;
                if (in_lo_r) begin
                    status_nxt[irq_ctrl_pkg::ST_NEST] = 1'b1;
                end
            end else begin
                in_lo_nxt = 1'b1;
                status_nxt[irq_ctrl_pkg::ST_TAKEN_LO] = 1'b1;
            end
            // taken offer leaves no stale selection or level behind
            req_nxt  = 1'b0;
            sel_nxt  = '0;
            high_nxt = 1'b0;
        end else if (RETI_IN) begin
            if (in_hi_r) begin
                in_hi_nxt = 1'b0;
            end else begin
                in_lo_nxt = 1'b0;
            end
        end
        if (priority_circuit_off) begin
            in_hi_nxt = 1'b0;
        end
        // write-one-to-clear, set wins only where the bit was clear before
        if (do_write && w_strb0_nxt && aw_addr_nxt == irq_ctrl_pkg::OFF_STATUS) begin
            status_nxt = status_nxt & ~(w_data_nxt[2:0] & ~(status_nxt ^ status_r));
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // axi write/read channels and registers
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb0_nxt = w_strb0_r;
        bvalid_nxt  = bvalid_r && !S_AXI_BREADY;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r && !S_AXI_RREADY;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        irq_enable_reg_nxt   = irq_enable_reg_r;
        irq_priority_reg_nxt = irq_priority_reg_r;
        mask_nxt    = mask_r;
        if (S_AXI_AWVALID && !aw_hold_r) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_hold_r) begin
            w_hold_nxt  = 1'b1;
            w_data_nxt  = S_AXI_WDATA;
            w_strb0_nxt = S_AXI_WSTRB[0];
        end
        do_write = aw_hold_r && w_hold_r && !bvalid_r;
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = known(aw_addr_r) ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
            if (w_strb0_r) begin
                unique case (aw_addr_r)
                    irq_ctrl_pkg::OFF_ENABLE:   irq_enable_reg_nxt = w_data_r[7:0];
                    irq_ctrl_pkg::OFF_PRIORITY: irq_priority_reg_nxt = w_data_r[7:0];
                    irq_ctrl_pkg::OFF_MASK:     mask_nxt = w_data_r[2:0];
                    default: ;
                endcase
            end
        end
        do_read = S_AXI_ARVALID && !rvalid_r;
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = known(S_AXI_ARADDR) ? irq_ctrl_pkg::RESP_OKAY
                                            : irq_ctrl_pkg::RESP_SLVERR;
            rdata_nxt  = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                irq_ctrl_pkg::OFF_ENABLE:
                    rdata_nxt[7:0] = irq_enable_reg_r | 8'h40;
                irq_ctrl_pkg::OFF_PRIORITY:
                    rdata_nxt[7:0] = irq_priority_reg_r | 8'h40;
                irq_ctrl_pkg::OFF_STATUS:  rdata_nxt[2:0] = status_r;
                irq_ctrl_pkg::OFF_MASK:    rdata_nxt[2:0] = mask_r;
                irq_ctrl_pkg::OFF_PENDING: rdata_nxt[N-1:0] = gated;
                irq_ctrl_pkg::OFF_SERVICE: rdata_nxt[1:0] = {in_hi_r, in_lo_r};
                default: ;
            endcase
        end
        awready_nxt = !aw_hold_nxt;
        wready_nxt  = !w_hold_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            irq_enable_reg_r   <= irq_ctrl_pkg::RST_ENABLE;
            irq_priority_reg_r <= irq_ctrl_pkg::RST_PRIORITY;
            status_r  <= 3'h0;
            mask_r    <= irq_ctrl_pkg::RST_MASK;
            in_hi_r   <= 1'b0;
            in_lo_r   <= 1'b0;
            req_r     <= 1'b0;
            sel_r     <= '0;
            high_r    <= 1'b0;
            irq_r     <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb0_r <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            rvalid_r  <= 1'b0;
            rresp_r   <= 2'h0;
            rdata_r   <= 32'h0000_0000;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
        end else begin
            irq_enable_reg_r   <= irq_enable_reg_nxt;
            irq_priority_reg_r <= irq_priority_reg_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
            in_hi_r   <= in_hi_nxt;
            in_lo_r   <= in_lo_nxt;
            req_r     <= req_nxt;
            sel_r     <= sel_nxt;
            high_r    <= high_nxt;
            irq_r     <= irq_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb0_r <= w_strb0_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign IRQ_REQ       = req_r;
    assign IRQ_SEL       = sel_r;
    assign IRQ_HIGH      = high_r;
    assign IRQ           = irq_r;
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY  = wready_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID  = rvalid_r;
    assign S_AXI_RRESP   = rresp_r;
    assign S_AXI_RDATA   = rdata_r;
endmodule

/* File: test/irq_ctrl_assertions.sv */
/* port checker for the interrupt enable/priority controller.
   assumes one clock MCLK and a synchronous active-high RESET. */
`timescale 1ns/100ps
module irq_ctrl_checker #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic         MCLK,
    input wire logic         RESET,
    // interrupt side
    input wire logic [N-1:0] IRQ_SRC,
    input wire logic         ACK_IN,
    input wire logic         RETI_IN,
    input wire logic         IRQ_REQ,
    input wire logic [N-1:0] IRQ_SEL,
    input wire logic         IRQ_HIGH,
    // read address and data
    input wire logic [7:0]   S_AXI_ARADDR,
    input wire logic         S_AXI_ARVALID,
    input wire logic         S_AXI_ARREADY,
    input wire logic [31:0]  S_AXI_RDATA,
    input wire logic         S_AXI_RVALID
);
    logic       hi_r, lo_r, hi_nxt, lo_nxt;
    logic [7:0] ra_r, ra_nxt;
    // service levels seen from the handshake
    always_comb begin
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        ra_nxt = ra_r;
        if (ACK_IN && IRQ_REQ) begin
            hi_nxt = hi_r | IRQ_HIGH;
            lo_nxt = lo_r | !IRQ_HIGH;
        end else if (RETI_IN) begin
            hi_nxt = 1'b0;
            lo_nxt = lo_r & hi_r;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) ra_nxt = S_AXI_ARADDR;
    end
    always_ff @(posedge MCLK) begin
        hi_r <= !RESET && hi_nxt;
        lo_r <= !RESET && lo_nxt;
        ra_r <= RESET ? 8'h00 : ra_nxt;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    AST_SEL_ONEHOT: assert property (IRQ_REQ |-> $onehot(IRQ_SEL))
        else $error("selection not one-hot");
    AST_SEL_SRC: assert property (IRQ_REQ |-> (IRQ_SEL & $past(IRQ_SRC)) != '0)
        else $error("selection without a request");
    AST_HIGH_REQ: assert property (IRQ_HIGH |-> IRQ_REQ)
        else $error("high flag without request");
    AST_SEL_IDLE: assert property (!IRQ_REQ |-> IRQ_SEL == '0 && !IRQ_HIGH)
        else $error("selection shown without request");
    AST_ACK_DROP: assert property (ACK_IN && IRQ_REQ |=> !IRQ_REQ)
        else $error("request held after ack");
    AST_HI_BLOCKS: assert property ($past(hi_r) |-> !IRQ_REQ)
        else $error("request during high service");
    AST_LO_ONLY_HIGH: assert property ($past(lo_r) && IRQ_REQ |-> IRQ_HIGH)
        else $error("low request during low service");
    AST_RSVD_ONE: assert property (S_AXI_RVALID && (ra_r == irq_ctrl_pkg::OFF_ENABLE
        || ra_r == irq_ctrl_pkg::OFF_PRIORITY) |-> S_AXI_RDATA[6])
        else $error("reserved bit read as zero");
endmodule
bind irq_enable_priority_ctrl irq_ctrl_checker #(.N(N)) u_irq_ctrl_checker (
    .MCLK(MCLK), .RESET(RESET), .IRQ_SRC(IRQ_SRC), .ACK_IN(ACK_IN), .RETI_IN(RETI_IN),
    .IRQ_REQ(IRQ_REQ), .IRQ_SEL(IRQ_SEL), .IRQ_HIGH(IRQ_HIGH),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID));

/* File: test/core_accept_model.sv */
/* core-side model: takes an offered request when allowed, returns on command.
   assumes the controller clock and synchronous reset. */
`timescale 1ns/100ps
module core_accept_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // controller handshake
    input  wire logic irq_req,
    output logic      ack_out,
    output logic      reti_out,
    // bench control
    input  wire logic accept,
    input  wire logic reti_cmd
);
    logic ack_nxt, reti_nxt;
    always_comb begin
        ack_nxt  = accept && irq_req && !ack_out;
        reti_nxt = reti_cmd && !reti_out;
    end
    always_ff @(posedge mclk) begin
        ack_out  <= !reset && ack_nxt;
        reti_out <= !reset && reti_nxt;
    end
endmodule

/* File: test/tb_top.sv */
/* bench for the interrupt enable/priority controller.
   assumes the core model and the bound port checker. */
`timescale 1ns/100ps
module tb_top;
    logic        mclk = 1'b0, reset = 1'b1, accept = 1'b0, reti_cmd = 1'b0, ack, reti;
    logic [5:0]  src = 6'h00, sel;
    logic        req, high, irq, awready, wready, bvalid, arready, rvalid;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  wstrb = 4'hf;
    int          num_errors = 0, samples_checked = 0;
    irq_enable_priority_ctrl u_irq_enable_priority_ctrl (
        .MCLK(mclk), .RESET(reset), .IRQ_SRC(src), .ACK_IN(ack), .RETI_IN(reti),
        .IRQ_REQ(req), .IRQ_SEL(sel), .IRQ_HIGH(high), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    core_accept_model u_core_accept_model (.mclk(mclk), .reset(reset), .irq_req(req),
        .accept(accept), .reti_cmd(reti_cmd), .ack_out(ack), .reti_out(reti));
    initial forever #10 mclk = ~mclk;
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er = irq_ctrl_pkg::RESP_OKAY,
                      input logic [3:0] st = 4'hf);
        logic pa = 1'b1, pw = 1'b1;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            pa = pa && !awready;
            pw = pw && !wready;
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp === er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = irq_ctrl_pkg::RESP_OKAY);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata === e && rresp === er, "read data");
    endtask
    task automatic drive(input logic [5:0] s);
        @(posedge mclk);
        src <= s;
        tick(3);
    endtask
    task automatic expect_req(input logic r, input logic [5:0] s, input logic h);
        check(req === r && (r === 1'b0 || (sel === s && high === h)), "offered request");
    endtask
    // core takes the offer, source then falls away
    task automatic take;
        @(posedge mclk);
        accept <= 1'b1;
        do @(posedge mclk); while (ack !== 1'b1);
        accept <= 1'b0;
        src <= 6'h00;
    endtask
    task automatic ret;
        @(posedge mclk);
        reti_cmd <= 1'b1;
        @(posedge mclk);
        reti_cmd <= 1'b0;
        tick(3);
    endtask
    task automatic s_regs;
        rd(irq_ctrl_pkg::OFF_ENABLE, 32'h40);
        rd(irq_ctrl_pkg::OFF_PRIORITY, 32'h40);
        wr(irq_ctrl_pkg::OFF_ENABLE, 8'h3f);
        rd(irq_ctrl_pkg::OFF_ENABLE, 32'h7f);
        // low strobe off: answered but nothing stored
        wr(irq_ctrl_pkg::OFF_ENABLE, 8'h00, irq_ctrl_pkg::RESP_OKAY, 4'he);
        rd(irq_ctrl_pkg::OFF_ENABLE, 32'h7f);
        wr(8'h10, 8'hff, irq_ctrl_pkg::RESP_SLVERR);
        rd(8'h10, 32'h0, irq_ctrl_pkg::RESP_SLVERR);
    endtask
    task automatic s_gate;
        drive(6'h3f);
        expect_req(1'b0, 6'h00, 1'b0);
        wr(irq_ctrl_pkg::OFF_ENABLE, 8'hbe);
        drive(6'h01);
        expect_req(1'b0, 6'h00, 1'b0);
        drive(6'h3f);
        expect_req(1'b1, 6'h02, 1'b0);
        rd(irq_ctrl_pkg::OFF_PENDING, 32'h3e);
    endtask
    task automatic s_prio;
        wr(irq_ctrl_pkg::OFF_ENABLE, 8'hbf);
        for (int k = 0; k < 6; k++) begin
            wr(irq_ctrl_pkg::OFF_PRIORITY, 8'h01 << k);
            tick(3);
            expect_req(1'b1, 6'h01 << k, 1'b1);
        end
        wr(irq_ctrl_pkg::OFF_PRIORITY, 8'ha0);
        tick(3);
        expect_req(1'b1, 6'h01, 1'b0);
        rd(irq_ctrl_pkg::OFF_PRIORITY, 32'he0);
        wr(irq_ctrl_pkg::OFF_PRIORITY, 8'h20);
        tick(3);
        expect_req(1'b1, 6'h20, 1'b1);
    endtask
    task automatic s_nest;
        wr(irq_ctrl_pkg::OFF_MASK, 8'h07);
        drive(6'h04);
        expect_req(1'b1, 6'h04, 1'b0);
        take();
        rd(irq_ctrl_pkg::OFF_SERVICE, 32'h01);
        drive(6'h02);
        expect_req(1'b0, 6'h00, 1'b0);
        drive(6'h22);
        expect_req(1'b1, 6'h20, 1'b1);
        take();
        rd(irq_ctrl_pkg::OFF_SERVICE, 32'h03);
        rd(irq_ctrl_pkg::OFF_STATUS, 32'h07);
        check(irq === 1'b1, "interrupt line set");
        drive(6'h02);
        ret();
        expect_req(1'b0, 6'h00, 1'b0);
        ret();
        expect_req(1'b1, 6'h02, 1'b0);
        take();
        ret();
        wr(irq_ctrl_pkg::OFF_MASK, 8'h00);
        tick(2);
        check(irq === 1'b0, "interrupt line masked");
        wr(irq_ctrl_pkg::OFF_STATUS, 8'h07);
        wr(irq_ctrl_pkg::OFF_MASK, 8'h07);
        rd(irq_ctrl_pkg::OFF_STATUS, 32'h00);
        check(irq === 1'b0, "interrupt line cleared");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(5000);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        tick(3);
        reset <= 1'b0;
        s_regs();
        s_gate();
        s_prio();
        s_nest();
        tally_and_finish();
    end
endmodule
